// ==== hw/ccc_cfg.svh ====
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH

// ============================================================
// Register offsets (byte addresses)
`define CCC_OFS_CTRL 8'h00
`define CCC_OFS_TIMING 8'h04
`define CCC_OFS_VECTOR 8'h08
`define CCC_OFS_FILT47 8'h0c
`define CCC_OFS_EVENT 8'h10
// FIFO interrupt registers: 8'h80 + 4 * n
`define CCC_FIFO_AREA_BIT 7

// ============================================================
// Control register fields
`define CCC_CTRL_MODE_HI 23
`define CCC_CTRL_MODE_LO 21
`define CCC_CTRL_ON 15
`define CCC_CTRL_IDLE_STOP 13
`define CCC_CTRL_BUSY 11
`define CCC_CTRL_DEPTH_HI 4
`define CCC_MODE_CONFIG 3'h4
`define CCC_MODE_RESET 3'h4
`define CCC_DEPTH_MAX 5'h12

// ============================================================
// Bit timing fields
`define CCC_TIM_BRP_HI 5
`define CCC_TIM_SJW_LO 6
`define CCC_TIM_SJW_HI 7
`define CCC_TIM_PROPAGATION_SEGMENT_LEN_LO 8
`define CCC_TIM_PROPAGATION_SEGMENT_LEN_HI 10
`define CCC_TIM_PH1_LO 11
`define CCC_TIM_PH1_HI 13
`define CCC_TIM_SAM 14
`define CCC_TIM_PH2_SEL 15
`define CCC_TIM_PH2_LO 16
`define CCC_TIM_PH2_HI 18

// ============================================================
// Vector and event fields
`define CCC_VEC_HIT_LO 8
`define CCC_VEC_HIT_HI 12
`define CCC_EVT_EN_LO 16
`define CCC_EVT_EN_HI 23
`define CCC_CODE_NONE 7'h40
`define CCC_FIFO_COUNT 32
`define CCC_EVT_COUNT 8
`define CCC_FILT_BASE 5'h04

`endif

// ==== hw/ccc_pkg.sv ====
package ccc_pkg;

    // ============================================================
    // Run state of the controller
    typedef enum logic [1:0] {
        RUN_OFF,
        RUN_ACTIVE,
        RUN_DRAIN
    } ccc_run_t;

    // Module events, one-cycle pulses, highest code first
    typedef struct packed {
        logic invalid_message_event;
        logic mode_change_event;
        logic timestamp_timer_event;
        logic bandwidth_error_event;
        logic system_error_event;
        logic receive_overrun_event;
        logic wakeup_event;
        logic bus_error_event;
    } ccc_evt_t;

    // Live occupancy of one FIFO
    typedef struct packed {
        logic full;
        logic half;
        logic empty;
        logic not_empty;
        logic overflow;
    } ccc_fifo_stat_t;

    // One filter control byte
    typedef struct packed {
        logic enable;
        logic [1:0] mask_choice;
        logic [4:0] fifo_choice;
    } ccc_filt_t;

    // Per-FIFO interrupt register state
    typedef struct packed {
        logic [2:0] tx_ie;
        logic [3:0] rx_ie;
        logic rx_overrun_flag;
    } ccc_fifo_st_t;

endpackage

// ==== hw/ccc_fifo_irq.sv ====
`timescale 1ns/1ps
`include "ccc_cfg.svh"

module ccc_fifo_irq (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    // Register access
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    // FIFO status
    input wire logic i_tx,
    input wire ccc_pkg::ccc_fifo_stat_t i_stat,
    output logic o_pend
);
    import ccc_pkg::*;

    ccc_fifo_st_t st_r;
    ccc_fifo_st_t st_nxt;
    logic [2:0] tx_flags;
    logic [3:0] rx_flags;

    // ============================================================
    // Live flags, except the sticky receive overrun
    // Space flag by direction
    assign tx_flags = {i_tx & ~i_stat.full, i_tx & i_stat.half,
                       i_tx & i_stat.empty};
    assign rx_flags = {st_r.rx_overrun_flag, ~i_tx & i_stat.full,
                       ~i_tx & i_stat.half, ~i_tx & i_stat.not_empty};

    assign o_pend = |(tx_flags & st_r.tx_ie) | |(rx_flags & st_r.rx_ie);

    assign o_rdata = {5'h00, st_r.tx_ie, 4'h0, st_r.rx_ie,
                      5'h00, tx_flags, 4'h0, rx_flags};

    // ============================================================
    // State update
    always_comb begin
        st_nxt = st_r;
        if (i_wr) begin
            st_nxt.tx_ie = i_wdata[26:24];
            st_nxt.rx_ie = i_wdata[19:16];
            st_nxt.rx_overrun_flag = st_r.rx_overrun_flag & i_wdata[3];
        end
        // Set wins over a clear in the same cycle
        if (i_stat.overflow) begin
            st_nxt.rx_overrun_flag = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // ccc_fifo_irq

// ==== hw/ccc_top.sv ====
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "ccc_cfg.svh"

module ccc_top (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    // Register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // System and protocol engine
    input wire logic I_SYS_IDLE,
    input wire logic I_XFER_BUSY,
    input wire ccc_pkg::ccc_evt_t I_EVENTS,
    output logic O_RUN,
    output logic O_BUSY,
    output logic O_TQ_TICK,
    output logic O_THREE_SAMPLE,
    output logic [3:0] O_PROP_TQ,
    output logic [2:0] O_SJW_TQ,
    output logic [3:0] O_PHASE1_TQ,
    output logic [3:0] O_PHASE2_TQ,
    output logic [4:0] O_DATA_DEPTH,
    // Acceptance filters 4..7
    input wire logic I_MATCH_VALID,
    input wire logic [3:0] I_MATCH,
    output logic [7:0] O_FILT_MASK_SEL,
    output logic O_ACCEPT,
    output logic [4:0] O_ACCEPT_FIFO,
    output logic [4:0] O_ACCEPT_FILTER,
    // FIFO status
    input wire logic [31:0] I_FIFO_TX,
    input wire ccc_pkg::ccc_fifo_stat_t [31:0] I_FIFO_STAT,
    output logic [31:0] O_FIFO_PEND,
    output logic [6:0] O_INTERRUPT_CODE
);
    import ccc_pkg::*;

    // ============================================================
    // State
    typedef struct packed {
        ccc_run_t run_state;
        logic [2:0] mode;
        logic on;
        logic idle_stop;
        logic [4:0] depth;
        logic [5:0] bit_rate_prescale;
        logic [1:0] resync_jump_width;
        logic [2:0] propagation_segment_len;
        logic [2:0] ph1;
        logic [2:0] ph2;
        logic ph2_prog;
        logic sam;
        ccc_filt_t [3:0] filt;
        logic [7:0] evt_flag;
        logic [7:0] evt_en;
        logic [4:0] matched_filter_number;
        logic [6:0] interrupt_code;
        logic busy;
        logic run;
        logic [6:0] tq_cnt;
        logic tq_tick;
        logic three_sample;
        logic [3:0] prop_tq;
        logic [2:0] sjw_tq;
        logic [3:0] ph1_tq;
        logic [3:0] ph2_tq;
        logic accept;
        logic [4:0] acc_fifo;
        logic [4:0] acc_filt;
        logic [31:0] fifo_pend;
        logic [31:0] rdata;
    } ccc_top_st_t;

    ccc_top_st_t st_r;
    ccc_top_st_t st_nxt;

    logic [31:0] fifo_pend;
    logic [31:0] fifo_rdata [`CCC_FIFO_COUNT];
    logic fifo_area;
    logic [4:0] fifo_idx;
    logic [7:0] evt_pend;

    assign fifo_area = I_ADDR[`CCC_FIFO_AREA_BIT];
    assign fifo_idx = I_ADDR[6:2];
    assign evt_pend = st_r.evt_flag & st_r.evt_en;

    // ============================================================
    // FIFO interrupt registers
    genvar gi;
    generate
        for (gi = 0; gi < `CCC_FIFO_COUNT; gi = gi + 1) begin : g_fifo
            ccc_fifo_irq u_fifo (
                .I_REF_CLK(I_REF_CLK),
                .I_RESETN(I_RESETN),
                .i_wr(I_WR && fifo_area && (fifo_idx == 5'(gi))),
                .i_wdata(I_WDATA),
                .o_rdata(fifo_rdata[gi]),
                .i_tx(I_FIFO_TX[gi]),
                .i_stat(I_FIFO_STAT[gi]),
                .o_pend(fifo_pend[gi])
            );
        end
    endgenerate

    // ============================================================
    // Next-state logic
    always_comb begin
        logic halted;
        logic found;
        logic [6:0] code;
        logic [6:0] tq_last;
        logic [2:0] ph2_eff;
        halted = 1'b0;
        found = 1'b0;
        code = `CCC_CODE_NONE;
        tq_last = {st_r.bit_rate_prescale, 1'b1};
        ph2_eff = st_r.ph2;
        st_nxt = st_r;
        st_nxt.accept = 1'b0;
        st_nxt.tq_tick = 1'b0;
        st_nxt.rdata = 32'h0000_0000;

        // Control register writes
        if (I_WR && !fifo_area && I_ADDR == `CCC_OFS_CTRL) begin
            st_nxt.mode = I_WDATA[`CCC_CTRL_MODE_HI:`CCC_CTRL_MODE_LO];
            st_nxt.on = I_WDATA[`CCC_CTRL_ON];
            st_nxt.idle_stop = I_WDATA[`CCC_CTRL_IDLE_STOP];
            if (I_WDATA[`CCC_CTRL_DEPTH_HI:0] <= `CCC_DEPTH_MAX) begin
                st_nxt.depth = I_WDATA[`CCC_CTRL_DEPTH_HI:0];
            end
        end

        if (I_WR && I_ADDR == `CCC_OFS_TIMING &&
            st_r.mode == `CCC_MODE_CONFIG) begin
            st_nxt.bit_rate_prescale = I_WDATA[`CCC_TIM_BRP_HI:0];
            st_nxt.resync_jump_width = I_WDATA[`CCC_TIM_SJW_HI:`CCC_TIM_SJW_LO];
            st_nxt.propagation_segment_len = I_WDATA[`CCC_TIM_PROPAGATION_SEGMENT_LEN_HI:`CCC_TIM_PROPAGATION_SEGMENT_LEN_LO];
            st_nxt.ph1 = I_WDATA[`CCC_TIM_PH1_HI:`CCC_TIM_PH1_LO];
            st_nxt.ph2 = I_WDATA[`CCC_TIM_PH2_HI:`CCC_TIM_PH2_LO];
            st_nxt.ph2_prog = I_WDATA[`CCC_TIM_PH2_SEL];
            st_nxt.sam = I_WDATA[`CCC_TIM_SAM];
        end

        // Byte lane locked while filter enabled
        if (I_WR && I_ADDR == `CCC_OFS_FILT47) begin
            for (int k = 0; k < 4; k++) begin
                if (!st_r.filt[k].enable) begin
                    st_nxt.filt[k] = I_WDATA[8*k +: 8];
                end
            end
        end

        // Event flags: write one to clear, set wins
        if (I_WR && I_ADDR == `CCC_OFS_EVENT) begin
            st_nxt.evt_flag = st_r.evt_flag & ~I_WDATA[7:0];
            st_nxt.evt_en = I_WDATA[`CCC_EVT_EN_HI:`CCC_EVT_EN_LO];
        end
        st_nxt.evt_flag = st_nxt.evt_flag | I_EVENTS;

        // ========================================================
        // Run state, drain on disable
        unique case (st_r.run_state)
            RUN_OFF: begin
                if (st_r.on) begin
                    st_nxt.run_state = RUN_ACTIVE;
                end
            end
            RUN_ACTIVE: begin
                if (!st_r.on) begin
                    st_nxt.run_state = RUN_DRAIN;
                end
            end
            RUN_DRAIN: begin
                if (st_r.on) begin
                    st_nxt.run_state = RUN_ACTIVE;
                end else if (!I_XFER_BUSY) begin
                    st_nxt.run_state = RUN_OFF;
                end
            end
        endcase
        st_nxt.busy = (st_nxt.run_state != RUN_OFF);
        halted = st_r.idle_stop && I_SYS_IDLE;
        st_nxt.run = (st_nxt.run_state != RUN_OFF) && !halted;

        // ========================================================
        // Time quantum divider
        // Quantum of 2*(prescale+1) clocks
        if (st_r.run) begin
            if (st_r.tq_cnt >= tq_last) begin
                st_nxt.tq_cnt = 7'h00;
                st_nxt.tq_tick = 1'b1;
            end else begin
                st_nxt.tq_cnt = st_r.tq_cnt + 7'h01;
            end
        end else begin
            st_nxt.tq_cnt = 7'h00;
        end

        st_nxt.prop_tq = {1'b0, st_r.propagation_segment_len} + 4'h1;
        st_nxt.sjw_tq = {1'b0, st_r.resync_jump_width} + 3'h1;
        st_nxt.ph1_tq = {1'b0, st_r.ph1} + 4'h1;
        // Auto phase two, never above phase one
        if (!st_r.ph2_prog || st_r.ph2 > st_r.ph1) begin
            ph2_eff = st_r.ph1;
        end
        st_nxt.ph2_tq = {1'b0, ph2_eff} + 4'h1;
        st_nxt.three_sample = st_r.sam && (st_r.bit_rate_prescale >= 6'h02);

        // ========================================================
        // Acceptance among filters 4..7
        if (I_MATCH_VALID) begin
            for (int k = 3; k >= 0; k--) begin
                if (I_MATCH[k] && st_r.filt[k].enable) begin
                    st_nxt.accept = 1'b1;
                    st_nxt.acc_fifo = st_r.filt[k].fifo_choice;
                    st_nxt.acc_filt = `CCC_FILT_BASE + 5'(k);
                end
            end
            if (st_nxt.accept) begin
                st_nxt.matched_filter_number = st_nxt.acc_filt;
            end
        end

        // ========================================================
        // Interrupt code, lowest source first
        // FIFO codes take precedence
        for (int f = 0; f < `CCC_FIFO_COUNT; f++) begin
            if (!found && fifo_pend[f]) begin
                found = 1'b1;
                code = 7'(f);
            end
        end
        for (int e = 0; e < `CCC_EVT_COUNT; e++) begin
            if (!found && evt_pend[e]) begin
                found = 1'b1;
                code = `CCC_CODE_NONE + 7'(e + 1);
            end
        end
        st_nxt.interrupt_code = code;
        st_nxt.fifo_pend = fifo_pend;

        // ========================================================
        // Read data, one cycle after strobe
        if (I_RD) begin
            if (fifo_area) begin
                st_nxt.rdata = fifo_rdata[fifo_idx];
            end else begin
                unique case (I_ADDR)
                    `CCC_OFS_CTRL: begin
                        st_nxt.rdata[`CCC_CTRL_MODE_HI:`CCC_CTRL_MODE_LO] =
                            st_r.mode;
                        st_nxt.rdata[`CCC_CTRL_ON] = st_r.on;
                        st_nxt.rdata[`CCC_CTRL_IDLE_STOP] = st_r.idle_stop;
                        st_nxt.rdata[`CCC_CTRL_BUSY] = st_r.busy;
                        st_nxt.rdata[`CCC_CTRL_DEPTH_HI:0] = st_r.depth;
                    end
                    `CCC_OFS_TIMING: begin
                        st_nxt.rdata[`CCC_TIM_PH2_HI:0] = {st_r.ph2,
                            st_r.ph2_prog, st_r.sam, st_r.ph1,
                            st_r.propagation_segment_len, st_r.resync_jump_width, st_r.bit_rate_prescale};
                    end
                    `CCC_OFS_VECTOR: begin
                        st_nxt.rdata[`CCC_VEC_HIT_HI:`CCC_VEC_HIT_LO] =
                            st_r.matched_filter_number;
                        st_nxt.rdata[6:0] = st_r.interrupt_code;
                    end
                    `CCC_OFS_FILT47: begin
                        st_nxt.rdata = st_r.filt;
                    end
                    `CCC_OFS_EVENT: begin
                        st_nxt.rdata[7:0] = st_r.evt_flag;
                        st_nxt.rdata[`CCC_EVT_EN_HI:`CCC_EVT_EN_LO] =
                            st_r.evt_en;
                    end
                    default: begin
                        // Unmapped reads return zero
                        st_nxt.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_r <= '0;
            st_r.mode <= `CCC_MODE_RESET;
            st_r.interrupt_code <= `CCC_CODE_NONE;
            st_r.run_state <= RUN_OFF;
            st_r.prop_tq <= 4'h1;
            st_r.sjw_tq <= 3'h1;
            st_r.ph1_tq <= 4'h1;
            st_r.ph2_tq <= 4'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs, all from flops
    assign O_RDATA = st_r.rdata;
    assign O_RUN = st_r.run;
    assign O_BUSY = st_r.busy;
    assign O_TQ_TICK = st_r.tq_tick;
    assign O_THREE_SAMPLE = st_r.three_sample;
    assign O_PROP_TQ = st_r.prop_tq;
    assign O_SJW_TQ = st_r.sjw_tq;
    assign O_PHASE1_TQ = st_r.ph1_tq;
    assign O_PHASE2_TQ = st_r.ph2_tq;
    assign O_DATA_DEPTH = st_r.depth;
    assign O_FILT_MASK_SEL = {st_r.filt[3].mask_choice,
                              st_r.filt[2].mask_choice,
                              st_r.filt[1].mask_choice,
                              st_r.filt[0].mask_choice};
    assign O_ACCEPT = st_r.accept;
    assign O_ACCEPT_FIFO = st_r.acc_fifo;
    assign O_ACCEPT_FILTER = st_r.acc_filt;
    assign O_FIFO_PEND = st_r.fifo_pend;
    assign O_INTERRUPT_CODE = st_r.interrupt_code;

endmodule // ccc_top

// ==== tb/ccc_top_properties.sv ====
`timescale 1ns/1ps

// ============================================================
// Port checker
module ccc_top_properties (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    // Watched inputs
    input wire logic I_XFER_BUSY,
    input wire logic I_MATCH_VALID,
    input wire logic [3:0] I_MATCH,
    // Watched outputs
    input wire logic O_RUN,
    input wire logic O_BUSY,
    input wire logic O_TQ_TICK,
    input wire logic O_THREE_SAMPLE,
    input wire logic [3:0] O_PROP_TQ,
    input wire logic [2:0] O_SJW_TQ,
    input wire logic [3:0] O_PHASE1_TQ,
    input wire logic [3:0] O_PHASE2_TQ,
    input wire logic [4:0] O_DATA_DEPTH,
    input wire logic O_ACCEPT,
    input wire logic [4:0] O_ACCEPT_FILTER,
    input wire logic [31:0] O_FIFO_PEND,
    input wire logic [6:0] O_INTERRUPT_CODE
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESETN);

    // Prescale of two or more gives quanta of six cycles at least
    sequence s_quiet;
        !O_TQ_TICK [*5];
    endsequence

    AST_PROP: assert property (
        O_PROP_TQ inside {[4'h1:4'h8]})
        else $error("prop length out of range");
    AST_SJW: assert property (
        O_SJW_TQ inside {[3'h1:3'h4]})
        else $error("jump width out of range");
    AST_PHASE2: assert property (
        O_PHASE2_TQ <= O_PHASE1_TQ)
        else $error("phase two above phase one");
    AST_DEPTH: assert property (
        O_DATA_DEPTH <= 5'h12)
        else $error("invalid data depth");
    AST_TICK_GAP: assert property (
        O_TQ_TICK |=> !O_TQ_TICK)
        else $error("quantum shorter than two cycles");
    AST_SAMPLE_GAP: assert property (
        O_TQ_TICK && O_THREE_SAMPLE |=> s_quiet)
        else $error("three-sample with short quantum");
    AST_RUN_BUSY: assert property (
        O_RUN |-> O_BUSY)
        else $error("running while not busy");
    AST_BUSY_FALL: assert property (
        $fell(O_BUSY) |-> !$past(I_XFER_BUSY))
        else $error("busy fell during transaction");
    AST_NO_HIT: assert property (
        I_MATCH_VALID && (I_MATCH == 4'h0) |=> !O_ACCEPT)
        else $error("accept without match");
    AST_HIT_NUM: assert property (
        O_ACCEPT |-> O_ACCEPT_FILTER inside {[5'h4:5'h7]})
        else $error("accepted filter out of range");
    AST_CODE_FIFO: assert property (
        (O_FIFO_PEND != 32'h0) |-> (O_INTERRUPT_CODE < 7'h20))
        else $error("fifo pending but code not fifo");
    AST_CODE_NONE: assert property (
        (O_FIFO_PEND == 32'h0) |-> (O_INTERRUPT_CODE >= 7'h40))
        else $error("fifo code without pending fifo");
endmodule // ccc_top_properties

bind ccc_top ccc_top_properties i_props (.*);

// ==== tb/ccc_engine_model.sv ====
`timescale 1ns/1ps

// ============================================================
// Protocol engine stand-in
module ccc_engine_model #(
    parameter int DRAIN_CYC = 6
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Controller state and bench commands
    input wire logic i_run,
    input wire logic [7:0] i_evt_req,
    input wire logic i_match_req,
    input wire logic [3:0] i_match_bits,
    // Engine outputs
    output logic o_xfer_busy,
    output ccc_pkg::ccc_evt_t o_events,
    output logic o_match_valid,
    output logic [3:0] o_match
);
    import ccc_pkg::*;
    int phase_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_r <= 0;
            o_xfer_busy <= 1'b0;
            o_events <= '0;
            o_match_valid <= 1'b0;
            o_match <= 4'h0;
        end else begin
            // Transactions with one-cycle gaps
            // Run stays high while draining, so a gap must come by itself
            phase_r <= (!i_run || phase_r == DRAIN_CYC) ? 0 : phase_r + 1;
            o_xfer_busy <= i_run && (phase_r != DRAIN_CYC);
            o_events <= ccc_evt_t'(i_evt_req);
            o_match_valid <= i_match_req;
            // Result lines invert every cycle outside a strobe, holding no steady value
            o_match <= i_match_req ? i_match_bits : ~o_match;
        end
    end
endmodule // ccc_engine_model

// ==== tb/tb_ccc_top.sv ====
`timescale 1ns/1ps

// ============================================================
// Bench top
module tb_ccc_top;
    import ccc_pkg::*;
    logic ref_clk, resetn, wr_stb, rd_stb, sys_idle, xfer_busy;
    logic m_req, m_valid, run, busy, tick, three, accept;
    logic [7:0] addr, evt_req, filt_sel;
    logic [31:0] wdata, rdata, fifo_tx, fifo_pend, v, f;
    logic [3:0] m_bits, m_in, prop_tq, ph1_tq, ph2_tq;
    logic [2:0] sjw_tq;
    logic [4:0] depth, acc_fifo, acc_filt;
    logic [6:0] interrupt_code;
    logic [15:0] tim_out;
    ccc_evt_t events;
    ccc_fifo_stat_t [31:0] fifo_stat;
    int seed, mismatches, total_checks, n;
    logic [7:0] rst_ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h80};
    logic [31:0] rst_val [6] = '{32'h0080_0000, 0, 32'h40, 0, 0, 0};
    assign tim_out = {prop_tq, sjw_tq, ph1_tq, ph2_tq, three};

    ccc_engine_model i_model (.i_clk(ref_clk), .i_resetn(resetn),
        .i_run(run), .i_evt_req(evt_req), .i_match_req(m_req),
        .i_match_bits(m_bits), .o_xfer_busy(xfer_busy), .o_events(events),
        .o_match_valid(m_valid), .o_match(m_in));
    ccc_top i_dut (.I_REF_CLK(ref_clk), .I_RESETN(resetn), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_stb), .I_RD(rd_stb), .O_RDATA(rdata),
        .I_SYS_IDLE(sys_idle), .I_XFER_BUSY(xfer_busy), .I_EVENTS(events),
        .O_RUN(run), .O_BUSY(busy), .O_TQ_TICK(tick),
        .O_THREE_SAMPLE(three), .O_PROP_TQ(prop_tq), .O_SJW_TQ(sjw_tq),
        .O_PHASE1_TQ(ph1_tq), .O_PHASE2_TQ(ph2_tq), .O_DATA_DEPTH(depth),
        .I_MATCH_VALID(m_valid), .I_MATCH(m_in), .O_FILT_MASK_SEL(filt_sel),
        .O_ACCEPT(accept), .O_ACCEPT_FIFO(acc_fifo),
        .O_ACCEPT_FILTER(acc_filt), .I_FIFO_TX(fifo_tx),
        .I_FIFO_STAT(fifo_stat), .O_FIFO_PEND(fifo_pend), .O_INTERRUPT_CODE(interrupt_code));

    function automatic logic [15:0] tim_exp(input logic [31:0] t);
        logic [2:0] p2;
        p2 = (t[15] && t[18:16] < t[13:11]) ? t[18:16] : t[13:11];
        return {{1'b0, t[10:8]} + 4'h1, {1'b0, t[7:6]} + 3'h1,
            {1'b0, t[13:11]} + 4'h1, {1'b0, p2} + 4'h1,
            t[14] && (t[5:0] >= 6'h2)};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask
    task automatic pulse(input logic [7:0] x);
        @(posedge ref_clk);
        evt_req <= x;
        @(posedge ref_clk);
        evt_req <= 8'h0;
        step(4);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end

    initial begin
        {seed, mismatches, total_checks} = {32'd63, 64'd0};
        {resetn, wr_stb, rd_stb, sys_idle, m_req} = '0;
        {addr, evt_req, wdata, m_bits, fifo_tx, fifo_stat} = '0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            bus_rd(rst_ofs[i], rst_val[i], '1);
        chk(tim_out, tim_exp(32'h0));
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = $random(seed) & 32'h0007_ffff;
            bus_wr(8'h04, v);
            bus_rd(8'h04, v, '1);
            chk(tim_out, tim_exp(v));
        end
        bus_wr(8'h00, 32'h0000_0012);
        step(2);
        chk(depth, 5'h12);
        bus_wr(8'h04, 32'h0007_ffff);
        bus_rd(8'h04, v, '1);
        bus_wr(8'h00, 32'h0080_0013);
        bus_rd(8'h00, 32'h0080_0012, '1);
        bus_wr(8'h40, '1);
        bus_rd(8'h40, 0, '1);
        $display("test timing done");
        f = ($random(seed) & 32'h7f7f_7f7f) | 32'h8000_8000;
        bus_wr(8'h0c, f);
        bus_rd(8'h0c, f, '1);
        chk(filt_sel, {f[30:29], f[22:21], f[14:13], f[6:5]});
        bus_wr(8'h0c, 32'h0);
        bus_rd(8'h0c, f & 32'hff00_ff00, '1);
        for (int m = 0; m < 16; m++) begin
            @(posedge ref_clk);
            m_req <= 1'b1;
            m_bits <= 4'(m);
            @(posedge ref_clk);
            m_req <= 1'b0;
            step(1);
            chk(accept, m[1] | m[3]);
            if (m[1])
                chk({acc_filt, acc_fifo}, {5'h5, f[12:8]});
            else if (m[3])
                chk({acc_filt, acc_fifo}, {5'h7, f[28:24]});
        end
        bus_rd(8'h08, 32'h500, 32'h1f00);
        $display("test filter done");
        pulse(8'h01);
        chk(interrupt_code, 7'h40);
        bus_wr(8'h10, 32'h00ff_00ff);
        for (int b = 0; b < 8; b++) begin
            pulse(8'h01 << b);
            chk(interrupt_code, 7'h41 + 7'(b));
            bus_wr(8'h10, 32'h00ff_0000 | (32'h1 << b));
            step(4);
            chk(interrupt_code, 7'h40);
        end
        pulse(8'h24);
        chk(interrupt_code, 7'h43);
        bus_wr(8'h10, 32'h00ff_0004);
        step(4);
        chk(interrupt_code, 7'h46);
        bus_wr(8'h10, 32'h00ff_0020);
        $display("test event done");
        bus_wr(8'h88, 32'h0001_0000);
        fifo_stat[2].not_empty <= 1'b1;
        fifo_tx[5] <= 1'b1;
        bus_wr(8'h94, 32'h0400_0000);
        step(4);
        chk(fifo_pend, 32'h24);
        chk(interrupt_code, 7'h02);
        bus_rd(8'h94, 32'h400, 32'h400);
        bus_rd(8'h98, 0, 32'h400);
        fifo_stat[2].not_empty <= 1'b0;
        step(4);
        chk(interrupt_code, 7'h05);
        fifo_stat[5].full <= 1'b1;
        bus_rd(8'h94, 0, 32'h400);
        bus_wr(8'h8c, 32'h0008_0000);
        fifo_stat[3].overflow <= 1'b1;
        @(posedge ref_clk);
        fifo_stat[3].overflow <= 1'b0;
        step(4);
        bus_rd(8'h8c, 32'h8, 32'h8);
        chk(interrupt_code, 7'h03);
        bus_wr(8'h8c, 32'h0008_0000);
        step(4);
        bus_rd(8'h8c, 0, 32'h8);
        chk(interrupt_code, 7'h40);
        $display("test fifo done");
        // Legal bit: 12 quanta, jump within phase two
        bus_wr(8'h04, 32'h0003_da43);
        bus_wr(8'h00, 32'h0080_8000);
        step(3);
        chk({run, busy}, 2'b11);
        n = 0;
        while (tick !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        n = 0;
        do begin
            step(1);
            n++;
        end while (tick !== 1'b1 && n < 300);
        chk(n, 8);
        bus_wr(8'h00, 32'h0080_a000);
        sys_idle <= 1'b1;
        step(3);
        chk({run, busy}, 2'b01);
        sys_idle <= 1'b0;
        step(3);
        chk({run, busy}, 2'b11);
        bus_rd(8'h00, 32'h800, 32'h800);
        // Disable just after a gap, so a transaction is under way
        n = 0;
        while (xfer_busy !== 1'b0 && n < 20) begin
            step(1);
            n++;
        end
        bus_wr(8'h00, 32'h0080_0000);
        step(3);
        chk(busy, 1'b1);
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        bus_rd(8'h00, 0, 32'h800);
        $display("test run done");
        complete_run();
    end
endmodule // tb_ccc_top
